// ### design/ocs_cfg.svh
// address map, field positions, reset values and code constants of the clock switch block
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH
`define OCS_ADDR_REQ        4'h0
`define OCS_ADDR_CUR        4'h1
`define OCS_ADDR_CTL        4'h2
`define OCS_ADDR_RDY        4'h3
`define OCS_ADDR_IFLAG      4'h4
`define OCS_ADDR_IMASK      4'h5
`define OCS_SRC_HI          6
`define OCS_SRC_LO          4
`define OCS_DIV_HI          3
`define OCS_DIV_LO          0
`define OCS_HOLD_BIT        7
`define OCS_PWR_BIT         6
`define OCS_BYP_BIT         5
`define OCS_OSCILLATOR_READY_BIT_BIT        4
`define OCS_NRDY_BIT        3
`define OCS_SRC_EXT         3'h7
`define OCS_SRC_HF1M        3'h6
`define OCS_SRC_RSV5        3'h5
`define OCS_SRC_LF          3'h4
`define OCS_SRC_SEC         3'h3
`define OCS_SRC_RSV2        3'h2
`define OCS_SRC_EXTPLL      3'h1
`define OCS_SRC_HFPLL       3'h0
`define OCS_DIV_MAX         4'h9
`define OCS_RST_SRC         3'h6
`define OCS_RST_DIV_HF      4'h2
`define OCS_RST_DIV_OTHER   4'h0
`define OCS_CTL_RESET       8'h00
`define OCS_IRQ_SWITCH      0
`endif

// ### design/ocs_pkg.sv
// types of the clock switch block
package ocs_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_HELD
    } ocs_state_t;
endpackage

// ### design/ocs_clock_switch.sv
// oscillator status, clock switch sequencer and register port
`timescale 1ns/1ps
`default_nettype none
`include "ocs_cfg.svh"

// Contract
// - current source field codes clock source
// - current divider field codes postscaler ratio
// - reset loads current and request fields from strap
// - hold set: interrupt, keep old source
// - hold clear: switch completes when ready
// - power select honoured only without bypass
// - bypass turns pins into clock input
// - oscillator ready when request equals current
// - new ready only during switch and ready
// - five oscillator ready flags and pll flag read back
// - pll flag needs pll and input ready
// - external runs in configured mode
// - unused positions read zero
// - ready sets flag, completion updates fields
// - reserved request selects fast internal
module ocs_clock_switch #(
    parameter logic [2:0] RESET_SRC = `OCS_RST_SRC // strap reset source
) (
    input  wire logic       clk,            // 40 MHz system clock
    input  wire logic       rst,            // async reset, high
    input  wire logic [3:0] regAddr,        // register index
    input  wire logic [7:0] regWdata,       // write data
    input  wire logic       regWr,          // write strobe
    input  wire logic       regRd,          // read strobe
    output logic      [7:0] regRdata,       // read data, next cycle
    input  wire logic       externalReady,  // oscillator ready inputs
    input  wire logic       fastIntReady,   // fast internal ready
    input  wire logic       slowIntReady,   // slow internal ready
    input  wire logic       secondaryReady, // secondary ready
    input  wire logic       convRcReady,    // converter rc ready
    input  wire logic       pllLocked,      // pll lock
    input  wire logic [2:0] extModeConfig,  // external mode config
    output logic      [2:0] activeSource,   // current source to mux
    output logic      [3:0] activeDivider,  // current divider
    output logic      [2:0] requestSource,  // source to enable
    output logic      [2:0] externalMode,   // mode to external osc
    output logic            secHighPower,   // secondary high power
    output logic            secBypass,      // secondary input is clock
    output logic            secOutPinUsed,  // output pin in crystal use
    output logic            irq             // level interrupt
);
    // synchronisers for asynchronous ready inputs
    logic [5:0] rdyMeta_ff;
    logic [5:0] rdySync_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdyMeta_ff <= 6'h00;
            rdySync_ff <= 6'h00;
        end else begin
            rdyMeta_ff <= {pllLocked, convRcReady, secondaryReady,
                           slowIntReady, fastIntReady, externalReady};
            rdySync_ff <= rdyMeta_ff;
        end
    end
    logic extR;
    logic hfR;
    logic lfR;
    logic secR;
    logic adR;
    logic pll_ready_flag;
    assign extR = rdySync_ff[0];
    assign hfR  = rdySync_ff[1];
    assign lfR  = rdySync_ff[2];
    assign secR = rdySync_ff[3];
    assign adR  = rdySync_ff[4];

    // registers
    logic [2:0] reqSrc_ff, nxt_reqSrc;
    logic [3:0] reqDiv_ff, nxt_reqDiv;
    logic [2:0] curSrc_ff, nxt_curSrc;
    logic [3:0] curDiv_ff, nxt_curDiv;
    logic       hold_ff, nxt_hold;
    logic       pwr_ff, nxt_pwr;
    logic       byp_ff, nxt_byp;
    logic       iflag_ff, nxt_iflag;
    logic       imask_ff, nxt_imask;
    logic [7:0] rdata_ff, nxt_rdata;
    ocs_pkg::ocs_state_t state_ff, nxt_state;

    // pll ready needs its input source ready too
    always_comb begin
        unique case (curSrc_ff)
            `OCS_SRC_EXTPLL: pll_ready_flag = rdySync_ff[5] & extR;
            `OCS_SRC_HFPLL:  pll_ready_flag = rdySync_ff[5] & hfR;
            default:         pll_ready_flag = 1'b0;
        endcase
    end

    // ready of the requested oscillator
    logic newReady;
    always_comb begin
        unique case (reqSrc_ff)
            `OCS_SRC_EXT:    newReady = extR;
            `OCS_SRC_HF1M:   newReady = hfR;
            `OCS_SRC_LF:     newReady = lfR;
            `OCS_SRC_SEC:    newReady = secR;
            `OCS_SRC_EXTPLL: newReady = extR & rdySync_ff[5];
            `OCS_SRC_HFPLL:  newReady = hfR & rdySync_ff[5];
            default:         newReady = hfR;
        endcase
    end

    logic mismatch;
    logic oscReady;
    logic newOscReady;
    assign mismatch    = (reqSrc_ff != curSrc_ff) || (reqDiv_ff != curDiv_ff);
    assign oscReady    = ~mismatch;
    assign newOscReady = mismatch & newReady;

    // reserved source request falls back to fast internal
    logic [2:0] wrSrc;
    logic [3:0] wrDiv;
    always_comb begin
        wrSrc = regWdata[`OCS_SRC_HI:`OCS_SRC_LO];
        if (wrSrc == `OCS_SRC_RSV5 || wrSrc == `OCS_SRC_RSV2) begin
            wrSrc = `OCS_SRC_HF1M;
        end
        wrDiv = regWdata[`OCS_DIV_HI:`OCS_DIV_LO];
        if (wrDiv > `OCS_DIV_MAX) begin
            wrDiv = curDiv_ff;
        end
    end

    // switch sequencer and register writes
    logic evtSwitch;
    always_comb begin
        nxt_reqSrc = reqSrc_ff;
        nxt_reqDiv = reqDiv_ff;
        nxt_curSrc = curSrc_ff;
        nxt_curDiv = curDiv_ff;
        nxt_hold   = hold_ff;
        nxt_pwr    = pwr_ff;
        nxt_byp    = byp_ff;
        nxt_imask  = imask_ff;
        nxt_state  = state_ff;
        evtSwitch  = 1'b0;
        unique case (state_ff)
            ocs_pkg::ST_IDLE: begin
                if (mismatch) begin
                    nxt_state = ocs_pkg::ST_WAIT;
                end
            end
            ocs_pkg::ST_WAIT: begin
                if (!mismatch) begin
                    nxt_state = ocs_pkg::ST_IDLE;
                end else if (newReady) begin
                    evtSwitch = 1'b1;
                    if (hold_ff) begin
                        nxt_state = ocs_pkg::ST_HELD;
                    end else begin
                        nxt_curSrc = reqSrc_ff;
                        nxt_curDiv = reqDiv_ff;
                        nxt_state  = ocs_pkg::ST_IDLE;
                    end
                end
            end
            ocs_pkg::ST_HELD: begin
                if (!mismatch) begin
                    nxt_state = ocs_pkg::ST_IDLE;
                end else if (!newReady) begin
                    nxt_state = ocs_pkg::ST_WAIT;
                end else if (!hold_ff) begin
                    nxt_curSrc = reqSrc_ff;
                    nxt_curDiv = reqDiv_ff;
                    nxt_state  = ocs_pkg::ST_IDLE;
                end
            end
        endcase
        if (regWr) begin
            unique case (regAddr)
                `OCS_ADDR_REQ: begin
                    nxt_reqSrc = wrSrc;
                    nxt_reqDiv = wrDiv;
                end
                `OCS_ADDR_CTL: begin
                    nxt_hold = regWdata[`OCS_HOLD_BIT];
                    nxt_pwr  = regWdata[`OCS_PWR_BIT];
                    nxt_byp  = regWdata[`OCS_BYP_BIT];
                end
                `OCS_ADDR_IMASK: nxt_imask = regWdata[`OCS_IRQ_SWITCH];
                default: ;
            endcase
        end
        // set beats write-one clear
        nxt_iflag = iflag_ff;
        if (regWr && regAddr == `OCS_ADDR_IFLAG &&
            regWdata[`OCS_IRQ_SWITCH]) begin
            nxt_iflag = 1'b0;
        end
        if (evtSwitch) begin
            nxt_iflag = 1'b1;
        end
    end

    // read mux, registered one cycle
    always_comb begin
        nxt_rdata = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                `OCS_ADDR_REQ: nxt_rdata = {1'b0, reqSrc_ff, reqDiv_ff};
                `OCS_ADDR_CUR: nxt_rdata = {1'b0, curSrc_ff, curDiv_ff};
                `OCS_ADDR_CTL: nxt_rdata = {hold_ff, pwr_ff, byp_ff,
                                            oscReady, newOscReady, 3'h0};
                `OCS_ADDR_RDY: nxt_rdata = {extR, hfR, 1'b0, lfR,
                                            secR, adR, 1'b0, pll_ready_flag};
                `OCS_ADDR_IFLAG: nxt_rdata = {7'h00, iflag_ff};
                `OCS_ADDR_IMASK: nxt_rdata = {7'h00, imask_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // reset loads request and current from one strap value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqSrc_ff <= RESET_SRC;
            reqDiv_ff <= (RESET_SRC == `OCS_SRC_HF1M) ? `OCS_RST_DIV_HF
                                                      : `OCS_RST_DIV_OTHER;
            curSrc_ff <= RESET_SRC;
            curDiv_ff <= (RESET_SRC == `OCS_SRC_HF1M) ? `OCS_RST_DIV_HF
                                                      : `OCS_RST_DIV_OTHER;
            hold_ff   <= 1'b0;
            pwr_ff    <= 1'b0;
            byp_ff    <= 1'b0;
            iflag_ff  <= 1'b0;
            imask_ff  <= 1'b0;
            rdata_ff  <= 8'h00;
            state_ff  <= ocs_pkg::ST_IDLE;
        end else begin
            reqSrc_ff <= nxt_reqSrc;
            reqDiv_ff <= nxt_reqDiv;
            curSrc_ff <= nxt_curSrc;
            curDiv_ff <= nxt_curDiv;
            hold_ff   <= nxt_hold;
            pwr_ff    <= nxt_pwr;
            byp_ff    <= nxt_byp;
            iflag_ff  <= nxt_iflag;
            imask_ff  <= nxt_imask;
            rdata_ff  <= nxt_rdata;
            state_ff  <= nxt_state;
        end
    end

    // outputs
    assign regRdata      = rdata_ff;
    assign activeSource  = curSrc_ff;
    assign activeDivider = curDiv_ff;
    assign requestSource = reqSrc_ff;
    assign externalMode  = extModeConfig;
    assign secHighPower  = pwr_ff & ~byp_ff;
    assign secBypass     = byp_ff;
    assign secOutPinUsed = ~byp_ff;
    assign irq           = iflag_ff & imask_ff;

    // checks
    a_hold_keeps_src: assert property (
        @(posedge clk) disable iff (rst)
        (hold_ff && state_ff == ocs_pkg::ST_HELD && $past(hold_ff))
        |=> $stable(curSrc_ff)) else $error("held switch changed source");
    a_held_sets_flag: assert property (
        @(posedge clk) disable iff (rst)
        (state_ff == ocs_pkg::ST_WAIT && mismatch && newReady && hold_ff)
        |=> state_ff == ocs_pkg::ST_HELD && iflag_ff && $stable(curSrc_ff))
        else $error("held switch not flagged");
    a_ready_sets_flag: assert property (
        @(posedge clk) disable iff (rst)
        (state_ff == ocs_pkg::ST_WAIT && mismatch && newReady)
        |=> iflag_ff) else $error("switch flag not set");
    a_switch_done: assert property (
        @(posedge clk) disable iff (rst)
        (state_ff == ocs_pkg::ST_WAIT && mismatch && newReady && !hold_ff
         && !regWr) |=> (curSrc_ff == $past(reqSrc_ff)) && oscReady)
        else $error("switch did not complete");
    a_new_rdy_zero: assert property (
        @(posedge clk) disable iff (rst)
        oscReady |-> !newOscReady) else $error("new ready while idle");
    a_src_not_rsv: assert property (
        @(posedge clk) disable iff (rst)
        curSrc_ff != `OCS_SRC_RSV5 && curSrc_ff != `OCS_SRC_RSV2)
        else $error("reserved source active");
    a_req_not_rsv: assert property (
        @(posedge clk) disable iff (rst)
        reqSrc_ff != `OCS_SRC_RSV5 && reqSrc_ff != `OCS_SRC_RSV2)
        else $error("reserved source requested");
    a_div_in_range: assert property (
        @(posedge clk) disable iff (rst)
        curDiv_ff <= `OCS_DIV_MAX) else $error("reserved divider active");
    a_power_bypass: assert property (
        @(posedge clk) disable iff (rst)
        byp_ff |-> !secHighPower) else $error("power honoured in bypass");
    a_unused_zero: assert property (
        @(posedge clk) disable iff (rst)
        $past(regRd) && $past(regAddr) == `OCS_ADDR_CTL
        |-> regRdata[2:0] == 3'h0) else $error("unused bits nonzero");
    a_pll_needs_in: assert property (
        @(posedge clk) disable iff (rst)
        (curSrc_ff == `OCS_SRC_EXTPLL && !extR) |-> !pll_ready_flag)
        else $error("pll ready without input");
    a_idle_keeps_cur: assert property (
        @(posedge clk) disable iff (rst)
        state_ff == ocs_pkg::ST_IDLE
        |=> $stable(curSrc_ff) && $stable(curDiv_ff))
        else $error("current moved while idle");
endmodule // ocs_clock_switch
`default_nettype wire

// ### sim/ocs_osc_model.sv
// oscillator sources and pll model facing the clock switch block
`timescale 1ns/1ps
`default_nettype none
module ocs_osc_model #(
    parameter int DLY = 4 // start-up cycles of every source
) (
    input  wire logic       clk,    // system clock
    input  wire logic       rst,    // async reset, high
    input  wire logic [4:0] enable, // ext,fast,slow,sec,rc running
    input  wire logic [2:0] reqSrc, // requested source
    input  wire logic [2:0] curSrc, // current source
    output logic      [4:0] ready,  // ready levels, same order
    output logic            pllLock // pll locked
);
    int cnt [5];
    logic pllIn;
    // a source reports ready only after its start-up time, drops at once
    always @(posedge clk or posedge rst) begin
        for (int i = 0; i < 5; i++) begin
            if (rst || !enable[i]) begin
                cnt[i] <= 0;
                ready[i] <= 1'b0;
            end else begin
                cnt[i] <= (cnt[i] < DLY) ? cnt[i] + 1 : cnt[i];
                ready[i] <= (cnt[i] >= DLY);
            end
        end
    end
    // the pll locks only while a pll choice is in use and its input runs
    always_comb begin
        pllIn = (reqSrc == 3'h0 || curSrc == 3'h0) ? ready[3] : ready[4];
        pllLock = pllIn && (reqSrc <= 3'h1 || curSrc <= 3'h1);
    end
endmodule // ocs_osc_model
`default_nettype wire

// ### sim/tb.sv
// self-checking bench of the clock switch block
`timescale 1ns/1ps
`default_nettype none
`include "ocs_cfg.svh"
module tb;
    logic       clk, rst, regWr, regRd, irq, pllLock;
    logic [3:0] regAddr, activeDivider;
    logic [7:0] regWdata, regRdata;
    logic [4:0] enable, rdy;
    logic [2:0] extModeConfig, activeSource, requestSource, externalMode;
    logic       secHighPower, secBypass, secOutPinUsed;
    logic       rdSeen = 1'b0;
    logic [7:0] expQ [$];
    logic [2:0] srcTab [6] = '{3'h7, 3'h6, 3'h4, 3'h3, 3'h1, 3'h0};
    int         badCount, testsRun;

    ocs_clock_switch DUT (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .externalReady(rdy[4]),
        .fastIntReady(rdy[3]), .slowIntReady(rdy[2]),
        .secondaryReady(rdy[1]), .convRcReady(rdy[0]),
        .pllLocked(pllLock), .extModeConfig(extModeConfig),
        .activeSource(activeSource), .activeDivider(activeDivider),
        .requestSource(requestSource), .externalMode(externalMode),
        .secHighPower(secHighPower), .secBypass(secBypass),
        .secOutPinUsed(secOutPinUsed), .irq(irq));
    ocs_osc_model osc (.clk(clk), .rst(rst), .enable(enable),
        .reqSrc(requestSource), .curSrc(activeSource), .ready(rdy),
        .pllLock(pllLock));

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one write strobe, then an idle cycle
    task automatic wr(logic [3:0] a, logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    // one read strobe; the monitor compares the answer
    task automatic rd(logic [3:0] a, logic [7:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back(exp);
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
    endtask
    // bounded wait for the interrupt or for a current source and divider
    task automatic waitFor(bit onIrq, logic [6:0] cur);
        int n;
        for (n = 0; n < 80; n++) begin
            if (onIrq ? irq === 1'b1 : {activeSource, activeDivider} === cur)
                break;
            @(posedge clk);
        end
        if (n == 80) begin
            badCount++;
            $display("mismatch wait expected %h seen timeout", cur);
            tallyAndFinish();
        end
    endtask
    task automatic done(string name);
        $display("test %s finished", name);
    endtask

    // read answers stand in the cycle after the strobe only
    always @(posedge clk) begin
        if (rdSeen)
            check("regRdata", regRdata, expQ.pop_front());
        rdSeen <= regRd;
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        tallyAndFinish();
    end
    initial begin
        logic [2:0] s, m;
        logic [3:0] d;
        rst = 1'b1;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        enable = 5'h1F;
        extModeConfig = 3'h0;
        badCount = 0;
        testsRun = 0;
        void'($urandom(74));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        rd(`OCS_ADDR_CUR, 8'h62);
        rd(`OCS_ADDR_REQ, 8'h62);
        rd(`OCS_ADDR_CTL, 8'h10);
        rd(`OCS_ADDR_RDY, 8'hDC);
        rd(4'h7, 8'h00);
        done("reset");
        wr(`OCS_ADDR_REQ, 8'h43);
        waitFor(1'b0, 7'h43);
        rd(`OCS_ADDR_CUR, 8'h43);
        rd(`OCS_ADDR_CTL, 8'h10);
        rd(`OCS_ADDR_IFLAG, 8'h01);
        check("irq", {7'h0, irq}, 8'h00);
        wr(`OCS_ADDR_IMASK, 8'h01);
        check("irq", {7'h0, irq}, 8'h01);
        wr(`OCS_ADDR_IFLAG, 8'h01);
        check("irq", {7'h0, irq}, 8'h00);
        done("switch");
        enable <= 5'h1D;
        wr(`OCS_ADDR_CTL, 8'h80);
        wr(`OCS_ADDR_REQ, 8'h30);
        repeat (4) @(posedge clk);
        rd(`OCS_ADDR_CTL, 8'h80);
        enable <= 5'h1F;
        waitFor(1'b1, 7'h00);
        rd(`OCS_ADDR_CTL, 8'h88);
        rd(`OCS_ADDR_CUR, 8'h43);
        check("active", {1'b0, activeSource, activeDivider}, 8'h43);
        wr(`OCS_ADDR_CTL, 8'h00);
        waitFor(1'b0, 7'h30);
        rd(`OCS_ADDR_CUR, 8'h30);
        rd(`OCS_ADDR_CTL, 8'h10);
        wr(`OCS_ADDR_IFLAG, 8'h01);
        done("hold");
        wr(`OCS_ADDR_REQ, 8'h52);
        rd(`OCS_ADDR_REQ, 8'h62);
        check("reqsrc", {5'h0, requestSource}, 8'h06);
        wr(`OCS_ADDR_REQ, 8'h6A);
        rd(`OCS_ADDR_REQ, 8'h62);
        waitFor(1'b0, 7'h62);
        wr(`OCS_ADDR_CTL, 8'h40);
        check("power", {7'h0, secHighPower}, 8'h01);
        check("outpin", {7'h0, secOutPinUsed}, 8'h01);
        wr(`OCS_ADDR_CTL, 8'hFF);
        rd(`OCS_ADDR_CTL, 8'hF0);
        check("power", {7'h0, secHighPower}, 8'h00);
        check("bypass", {7'h0, secBypass}, 8'h01);
        check("outpin", {7'h0, secOutPinUsed}, 8'h00);
        wr(`OCS_ADDR_CTL, 8'h00);
        wr(`OCS_ADDR_CUR, 8'h00);
        rd(`OCS_ADDR_CUR, 8'h62);
        wr(`OCS_ADDR_RDY, 8'h00);
        rd(`OCS_ADDR_RDY, 8'hDC);
        done("fields");
        // every non-reserved source code with a random legal divider and external mode
        for (int i = 0; i < 6; i++) begin
            s = srcTab[i];
            d = 4'($urandom_range(9, 0));
            m = 3'($urandom);
            extModeConfig <= m;
            wr(`OCS_ADDR_REQ, {1'b0, s, d});
            waitFor(1'b0, {s, d});
            rd(`OCS_ADDR_CUR, {1'b0, s, d});
            rd(`OCS_ADDR_RDY, {7'h6E, s <= 3'h1});
            check("extmode", {5'h0, externalMode}, {5'h0, m});
        end
        enable <= 5'h17;
        repeat (6) @(posedge clk);
        rd(`OCS_ADDR_RDY, 8'h9C);
        enable <= 5'h1F;
        done("sources");
        wr(`OCS_ADDR_CTL, 8'h80);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`OCS_ADDR_CTL, 8'h10);
        rd(`OCS_ADDR_CUR, 8'h62);
        check("active", {1'b0, activeSource, activeDivider}, 8'h62);
        @(posedge clk);
        done("rereset");
        tallyAndFinish();
    end
endmodule // tb
`default_nettype wire
